// [design/path_trace_cfg.svh]
// Offsets, field positions, reset values and timing counts of the path trace monitor
`ifndef PATH_TRACE_CFG_SVH
`define PATH_TRACE_CFG_SVH

// Clock and refresh timing
`define CLK_PERIOD_NS 100
`define REFRESH_MS 2000

// Trace string geometry
`define LONG_LEN 64
`define SHORT_LEN 16
`define LONG_LAST 6'h3F
`define SHORT_LAST 6'h0F

// Special characters
`define CHAR_NUL 8'h00
`define CHAR_CR 8'h0D
`define CHAR_LF 8'h0A

// Register byte addresses
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_INT_STAT 12'h008
`define REG_INT_MASK 12'h00C

// Address regions, selected by address bits 10:8
`define REGION_REGS 3'h0
`define REGION_TX 3'h1
`define REGION_PROV 3'h2
`define REGION_BASE 3'h3
`define REGION_RXREP 3'h4
`define REGION_EXPREP 3'h5

// Control register fields
`define CTRL_MODE_LSB 0
`define CTRL_SUP_TIM 2
`define CTRL_SUP_C2 3
`define CTRL_RX_ONLY 4
`define CTRL_TX_LONG 5
`define CTRL_DEFAULT 6
`define CTRL_W 6
`define CTRL_RESET 6'h00

// Trace mode encodings
`define MODE_OFF 2'h0
`define MODE_AUTO 2'h1
`define MODE_MANUAL 2'h2

// Interrupt status and mask fields
`define INT_TIM_SET 0
`define INT_TIM_CLR 1
`define INT_LEARNED 2
`define INT_FMT 3
`define INT_W 4
`define INT_MASK_RESET 4'h0

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [design/path_trace_pkg.sv]
// Types shared by the path trace monitor design files
package path_trace_pkg;
   typedef logic [7:0] char_t;
   typedef logic [5:0] cidx_t;
   typedef enum logic [1:0] {RD_IDLE, RD_MEM, RD_RESP} rd_state_t;
endpackage

// [design/trace_mem.sv]
// Sixty-four character string store with one write and two registered read ports
`timescale 1ns/100ps
module trace_mem
   import path_trace_pkg::*;
(
   // Clock
   input wire logic clk,
   // Write port
   input wire logic we,
   input wire cidx_t waddr,
   input wire char_t wdata,
   // Read port for the trace logic
   input wire cidx_t raddr_a,
   output char_t rdata_a,
   // Read port for the register bus
   input wire cidx_t raddr_b,
   output char_t rdata_b
);
   // Character array, no reset: the owner sweeps only the transmit and provisioned stores clear
   char_t mem [0:63];

   // Write and registered reads
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata_a <= mem[raddr_a];
      rdata_b <= mem[raddr_b];
   end
endmodule

// [design/path_trace_monitor.sv]
// Path trace byte generator and trace identifier mismatch monitor with AXI4-Lite registers
`timescale 1ns/100ps
`include "path_trace_cfg.svh"

module path_trace_monitor
   import path_trace_pkg::*;
#(
   parameter int unsigned REFRESH_CYCLES = `REFRESH_MS * (1000000 / `CLK_PERIOD_NS)
)
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write channels
   input wire logic [11:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read channels
   input wire logic [11:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Path overhead link from the framer
   input wire logic j1_slot,
   input wire char_t rx_j1,
   output char_t tx_j1,
   input wire logic path_defect,
   input wire logic c2_mismatch,
   // Alarms and interrupt
   output logic tim_alarm,
   output logic ais_out,
   output logic rdi_out,
   output logic irq
);
   // Bus state
   logic aw_got_reg, w_got_reg;
   logic [11:0] aw_addr_reg, ar_addr_reg;
   logic [31:0] w_data_reg;
   logic w_lane0_reg;
   rd_state_t rd_state_reg;
   // Control and interrupt registers
   logic [`CTRL_W-1:0] ctrl_reg;
   logic [`INT_W-1:0] int_stat_reg, int_mask_reg, int_stat_next, int_ev;
   // Clear sweep
   logic clr_active_reg;
   cidx_t clr_idx_reg;
   // Transmit side
   cidx_t tx_idx_reg;
   // Receive side
   cidx_t idx_reg;
   logic aligned_reg, rx_long_reg, prev_cr_reg, str_ok_reg, acc_reg;
   logic learned_reg, learn_run_reg, snap_arm_reg, snap_run_reg;
   logic [31:0] refresh_cnt_reg;

   // Field views of the control register
   wire [1:0] mode = ctrl_reg[`CTRL_MODE_LSB +: 2];
   wire sup_tim = ctrl_reg[`CTRL_SUP_TIM];
   wire sup_c2 = ctrl_reg[`CTRL_SUP_C2];
   wire rx_only = ctrl_reg[`CTRL_RX_ONLY];
   wire tx_long = ctrl_reg[`CTRL_TX_LONG];
   wire mode_auto = (mode == `MODE_AUTO);
   wire mode_man = (mode == `MODE_MANUAL);

   // Write decode
   wire wr_fire = aw_got_reg & w_got_reg & ~bvalid & ~clr_active_reg;
   wire [2:0] wr_region = aw_addr_reg[10:8];
   wire cidx_t wr_idx = aw_addr_reg[7:2];
   wire wr_in_map = ~aw_addr_reg[11];
   wire wr_ctrl_hit = (aw_addr_reg == `REG_CTRL);
   wire wr_mask_hit = (aw_addr_reg == `REG_INT_MASK);
   wire wr_tx_hit = wr_in_map & (wr_region == `REGION_TX);
   wire wr_prov_hit = wr_in_map & (wr_region == `REGION_PROV);
   wire wr_ok = wr_ctrl_hit | wr_mask_hit | wr_tx_hit | wr_prov_hit;
   wire wr_ctrl = wr_fire & wr_ctrl_hit & w_lane0_reg;
   wire wr_default = wr_ctrl & w_data_reg[`CTRL_DEFAULT];
   wire wr_mask = wr_fire & wr_mask_hit & w_lane0_reg;
   wire wr_tx = wr_fire & wr_tx_hit & w_lane0_reg;
   wire wr_prov = wr_fire & wr_prov_hit & w_lane0_reg;

   // Memory write ports: the clear sweep owns them while active
   wire tx_we = clr_active_reg | wr_tx;
   wire prov_we = clr_active_reg | wr_prov;
   wire cidx_t prov_waddr = clr_active_reg ? clr_idx_reg : wr_idx;
   wire char_t prov_wdata = clr_active_reg ? `CHAR_NUL : w_data_reg[7:0];

   // Receive character classification and alignment
   wire mark_short = rx_j1[7];
   wire mark_long = prev_cr_reg & (rx_j1 == `CHAR_LF);
   wire cidx_t pos = mark_short ? 6'h00 : (mark_long ? `LONG_LAST : idx_reg);
   wire fmt_next = mark_short ? 1'b0 : (mark_long ? 1'b1 : rx_long_reg);
   wire consist = aligned_reg & (rx_long_reg ? (((idx_reg == `LONG_LAST) == mark_long) & ~mark_short)
                                             : ((idx_reg == 6'h00) == mark_short));
   wire rx_last = fmt_next ? (pos == `LONG_LAST) : (pos == `SHORT_LAST);
   wire rx_go = j1_slot & consist;
   wire at_start = (pos == 6'h00);
   wire chk_ok = str_ok_reg | at_start;

   // Expected character source and comparison
   wire char_t prov_char, base_char, tx_char;
   wire char_t tx_rd_b, prov_rd_b, base_rd_b, rxrep_rd_b, exprep_rd_b;
   wire char_t exp_char = mode_man ? prov_char : base_char;
   wire acc_next = (at_start ? 1'b0 : acc_reg) | (rx_j1 != exp_char);
   wire cmp_en = mode_man | (mode_auto & learned_reg);
   wire str_done = rx_go & rx_last & chk_ok;
   wire tim_next = (mode == `MODE_OFF) ? 1'b0 : ((str_done & cmp_en) ? acc_next : tim_alarm);

   // Learning and report snapshot write strobes
   wire learn_wr = rx_go & mode_auto & ~learned_reg & (at_start | learn_run_reg);
   wire snap_wr = rx_go & (at_start ? snap_arm_reg : snap_run_reg);
   wire refresh_tick = (refresh_cnt_reg == REFRESH_CYCLES - 1);

   // Read decode on the latched address
   wire [2:0] rd_region = ar_addr_reg[10:8];
   wire cidx_t rd_idx = ar_addr_reg[7:2];
   wire rd_in_map = ~ar_addr_reg[11];
   wire rd_is_stat = (ar_addr_reg == `REG_INT_STAT);
   // Read clear lands on the edge that captures the answer
   wire rd_clr = (rd_state_reg == RD_RESP) & ~rvalid & rd_is_stat;
   wire [31:0] status_word = {25'h0000000, clr_active_reg, rdi_out, ais_out, learned_reg,
                              aligned_reg, rx_long_reg, tim_alarm};
   logic [31:0] rd_word;
   logic rd_ok;

   // Register and string read multiplexer
   always_comb begin
      rd_word = 32'h00000000;
      rd_ok = rd_in_map;
      case (rd_region)
         `REGION_REGS: begin
            if (ar_addr_reg == `REG_CTRL) begin
               rd_word = {26'h0000000, ctrl_reg};
            end else if (ar_addr_reg == `REG_STATUS) begin
               rd_word = status_word;
            end else if (rd_is_stat) begin
               rd_word = {28'h0000000, int_stat_reg};
            end else if (ar_addr_reg == `REG_INT_MASK) begin
               rd_word = {28'h0000000, int_mask_reg};
            end else begin
               rd_ok = 1'b0;
            end
         end
         `REGION_TX: rd_word = {24'h000000, tx_rd_b};
         `REGION_PROV: rd_word = {24'h000000, prov_rd_b};
         `REGION_BASE: rd_word = {24'h000000, base_rd_b};
         `REGION_RXREP: rd_word = {24'h000000, rxrep_rd_b};
         `REGION_EXPREP: rd_word = {24'h000000, exprep_rd_b};
         default: rd_ok = 1'b0;
      endcase
   end

   // Interrupt events, the set wins over a read clear
   always_comb begin
      int_ev = '0;
      int_ev[`INT_TIM_SET] = tim_next & ~tim_alarm;
      int_ev[`INT_TIM_CLR] = ~tim_next & tim_alarm;
      int_ev[`INT_LEARNED] = learn_wr & rx_last;
      int_ev[`INT_FMT] = j1_slot & aligned_reg & (fmt_next != rx_long_reg);
      int_stat_next = (rd_clr ? '0 : int_stat_reg) | int_ev;
   end

   // String stores
   trace_mem tx_mem (
      .clk(aclk), .we(tx_we), .waddr(prov_waddr), .wdata(prov_wdata),
      .raddr_a(tx_idx_reg), .rdata_a(tx_char), .raddr_b(rd_idx), .rdata_b(tx_rd_b)
   );
   trace_mem prov_mem (
      .clk(aclk), .we(prov_we), .waddr(prov_waddr), .wdata(prov_wdata),
      .raddr_a(idx_reg), .rdata_a(prov_char), .raddr_b(rd_idx), .rdata_b(prov_rd_b)
   );
   trace_mem base_mem (
      .clk(aclk), .we(learn_wr), .waddr(pos), .wdata(rx_j1),
      .raddr_a(idx_reg), .rdata_a(base_char), .raddr_b(rd_idx), .rdata_b(base_rd_b)
   );
   trace_mem rxrep_mem (
      .clk(aclk), .we(snap_wr), .waddr(pos), .wdata(rx_j1),
      .raddr_a(6'h00), .rdata_a(), .raddr_b(rd_idx), .rdata_b(rxrep_rd_b)
   );
   trace_mem exprep_mem (
      .clk(aclk), .we(snap_wr), .waddr(pos), .wdata(mode_auto & ~learned_reg ? rx_j1 : exp_char),
      .raddr_a(6'h00), .rdata_a(), .raddr_b(rd_idx), .rdata_b(exprep_rd_b)
   );

   // Write address and data capture, either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         aw_addr_reg <= 12'h000;
         w_data_reg <= 32'h00000000;
         w_lane0_reg <= 1'b0;
         awready <= 1'b1;
         wready <= 1'b1;
      end else begin
         if (awvalid & awready) begin
            aw_got_reg <= 1'b1;
            aw_addr_reg <= awaddr;
            awready <= 1'b0;
         end else if (wr_fire) begin
            aw_got_reg <= 1'b0;
         end else if (bvalid & bready) begin
            awready <= 1'b1;
         end
         if (wvalid & wready) begin
            w_got_reg <= 1'b1;
            w_data_reg <= wdata;
            w_lane0_reg <= wstrb[0];
            wready <= 1'b0;
         end else if (wr_fire) begin
            w_got_reg <= 1'b0;
         end else if (bvalid & bready) begin
            wready <= 1'b1;
         end
      end
   end

   // Write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= `RESP_OKAY;
      end else if (wr_fire) begin
         bvalid <= 1'b1;
         bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // Read sequence: latch address, wait for store, answer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state_reg <= RD_IDLE;
         ar_addr_reg <= 12'h000;
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= `RESP_OKAY;
      end else begin
         case (rd_state_reg)
            RD_IDLE: begin
               if (arvalid) begin
                  ar_addr_reg <= araddr;
                  arready <= 1'b0;
                  rd_state_reg <= RD_MEM;
               end
            end
            RD_MEM: begin
               // Stores read the latched address now; their output is a cycle late
               rd_state_reg <= RD_RESP;
            end
            RD_RESP: begin
               if (!rvalid) begin
                  rdata <= rd_word;
                  rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
                  rvalid <= 1'b1;
               end else if (rready) begin
                  rvalid <= 1'b0;
                  arready <= 1'b1;
                  rd_state_reg <= RD_IDLE;
               end
            end
            default: rd_state_reg <= RD_IDLE;
         endcase
      end
   end

   // Control, mask and interrupt status registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= `CTRL_RESET;
         int_mask_reg <= `INT_MASK_RESET;
         int_stat_reg <= '0;
         irq <= 1'b0;
      end else begin
         if (wr_default) begin
            ctrl_reg <= `CTRL_RESET;
         end else if (wr_ctrl) begin
            ctrl_reg <= w_data_reg[`CTRL_W-1:0];
         end
         if (wr_mask) begin
            int_mask_reg <= w_data_reg[`INT_W-1:0];
         end
         int_stat_reg <= int_stat_next;
         irq <= |(int_stat_next & int_mask_reg);
      end
   end

   // Clear sweep after reset and on a return to defaults
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clr_active_reg <= 1'b1;
         clr_idx_reg <= 6'h00;
      end else if (wr_default) begin
         clr_active_reg <= 1'b1;
         clr_idx_reg <= 6'h00;
      end else if (clr_active_reg) begin
         clr_active_reg <= (clr_idx_reg != `LONG_LAST);
         clr_idx_reg <= clr_idx_reg + 6'h01;
      end
   end

   // Transmit one character per frame, cycling through the string
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_idx_reg <= 6'h00;
         tx_j1 <= `CHAR_NUL;
      end else if (j1_slot) begin
         tx_j1 <= rx_only ? `CHAR_NUL : tx_char;
         if (tx_idx_reg == (tx_long ? `LONG_LAST : `SHORT_LAST)) begin
            tx_idx_reg <= 6'h00;
         end else begin
            tx_idx_reg <= tx_idx_reg + 6'h01;
         end
      end
   end

   // Receive alignment, format and string comparison
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         idx_reg <= 6'h00;
         aligned_reg <= 1'b0;
         rx_long_reg <= 1'b0;
         prev_cr_reg <= 1'b0;
         str_ok_reg <= 1'b0;
         acc_reg <= 1'b0;
         tim_alarm <= 1'b0;
      end else begin
         if (j1_slot) begin
            prev_cr_reg <= (rx_j1 == `CHAR_CR);
            aligned_reg <= aligned_reg | mark_short | mark_long;
            rx_long_reg <= fmt_next;
            idx_reg <= rx_last ? 6'h00 : pos + 6'h01;
            // Realignment abandons the string in flight
            str_ok_reg <= consist & (at_start | str_ok_reg) & ~rx_last;
         end
         if (rx_go) begin
            acc_reg <= acc_next;
         end
         tim_alarm <= tim_next;
      end
   end

   // Automatic baseline learning
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         learned_reg <= 1'b0;
         learn_run_reg <= 1'b0;
      end else if (!mode_auto) begin
         learned_reg <= 1'b0;
         learn_run_reg <= 1'b0;
      end else if (learn_wr) begin
         learned_reg <= rx_last;
         learn_run_reg <= ~rx_last;
      end else if (j1_slot & ~consist) begin
         learn_run_reg <= 1'b0;
      end
   end

   // Periodic report refresh
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         refresh_cnt_reg <= 32'h00000000;
         snap_arm_reg <= 1'b0;
         snap_run_reg <= 1'b0;
      end else begin
         refresh_cnt_reg <= refresh_tick ? 32'h00000000 : refresh_cnt_reg + 32'h00000001;
         if (mode == `MODE_OFF) begin
            snap_arm_reg <= 1'b0;
            snap_run_reg <= 1'b0;
         end else begin
            if (refresh_tick) begin
               snap_arm_reg <= 1'b1;
            end else if (snap_wr & at_start) begin
               snap_arm_reg <= 1'b0;
            end
            if (snap_wr) begin
               snap_run_reg <= ~rx_last;
            end else if (j1_slot & ~consist) begin
               snap_run_reg <= 1'b0;
            end
         end
      end
   end

   // Alarm consequences with suppression options
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ais_out <= 1'b0;
         rdi_out <= 1'b0;
      end else begin
         ais_out <= path_defect | (tim_alarm & ~sup_tim) | (c2_mismatch & ~sup_c2);
         rdi_out <= path_defect | (tim_alarm & ~sup_tim);
      end
   end
endmodule

// [verif/path_trace_monitor_properties.sv]
// Port-level concurrent checks for the path trace monitor
`timescale 1ns/100ps
module path_trace_monitor_properties
   import path_trace_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus handshakes
   input wire logic awready,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   // Path overhead link
   input wire logic j1_slot,
   input wire char_t tx_j1,
   input wire logic path_defect,
   input wire logic c2_mismatch,
   // Alarms
   input wire logic tim_alarm,
   input wire logic ais_out,
   input wire logic rdi_out,
   input wire logic irq
);
   // All checks share the bus clock and its reset
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   reset_state_a: assert property ($rose(aresetn) |-> awready && arready && !bvalid && !rvalid
      && tx_j1 == 8'h00 && !tim_alarm && !irq) else $error("outputs not idle after reset");
   tx_hold_a: assert property (!j1_slot |=> $stable(tx_j1))
      else $error("transmit byte changed outside a slot");
   tim_verdict_a: assert property ($rose(tim_alarm) |-> $past(j1_slot))
      else $error("mismatch raised away from a received character");
   ais_cause_a: assert property (ais_out |-> $past(path_defect || tim_alarm || c2_mismatch))
      else $error("AIS without a cause");
   rdi_cause_a: assert property (rdi_out |-> ais_out && $past(path_defect || tim_alarm))
      else $error("RDI without a cause");
   defect_force_a: assert property (path_defect |=> ais_out && rdi_out)
      else $error("path defect did not force AIS and RDI");
   bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped early");
   rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped early");
   read_answer_a: assert property (arvalid && arready |-> ##[1:3] rvalid)
      else $error("read answer late");
   write_busy_a: assert property ($rose(bvalid) |-> !awready && !wready)
      else $error("write channels ready while answering");
endmodule

bind path_trace_monitor path_trace_monitor_properties i_props (.aclk, .aresetn, .awready, .wready, .bvalid,
   .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata, .j1_slot, .tx_j1, .path_defect,
   .c2_mismatch, .tim_alarm, .ais_out, .rdi_out, .irq);

// [verif/far_end_model.sv]
// Far-end path terminating equipment: sends trace strings and records the bytes it receives
`timescale 1ns/100ps
module far_end_model
   import path_trace_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Path overhead link
   output logic j1_slot,
   output char_t rx_j1,
   input wire char_t tx_j1
);
   char_t str [64]; // String sent, loaded by the bench
   int len = 16; // Characters per string
   int gap = 4; // Cycles between slots, never under 2
   int cnt = 0; // Cycles since the last slot
   int idx = 0; // Next character to send
   logic seen = 1'b0; // Slot was offered on the previous edge
   char_t cap [$]; // Transmitted bytes, one per slot

   initial begin
      j1_slot = 1'b0;
      rx_j1 = 8'h00;
   end

   // One character per frame, the whole string repeated; one string for all members
   always @(posedge aclk) begin
      seen <= j1_slot;
      if (seen)
         cap.push_back(tx_j1);
      if (!aresetn || cnt < gap - 1) begin
         // Byte is not valid between slots, so keep it moving
         j1_slot <= 1'b0;
         rx_j1 <= ~rx_j1;
         cnt <= aresetn ? cnt + 1 : 0;
      end else begin
         j1_slot <= 1'b1;
         rx_j1 <= str[idx];
         idx <= (idx + 1) % len;
         cnt <= 0;
      end
   end
endmodule

// [verif/tb_top.sv]
// Self-checking bench for the path trace monitor
`timescale 1ns/100ps
`include "path_trace_cfg.svh"
module tb_top;
   import path_trace_pkg::*;
   // Register table rows: address, write flag, data, write answer, read data, read answer
   typedef struct {logic [11:0] a; logic w; logic [31:0] d; logic [1:0] wr; logic [31:0] e; logic [1:0] rr;} row_t;
   row_t rows [6] = '{'{`REG_CTRL, 0, 0, 0, 0, 0}, '{`REG_INT_MASK, 0, 0, 0, 0, 0},
      '{12'h100, 0, 0, 0, 0, 0}, '{12'h2FC, 0, 0, 0, 0, 0}, '{12'h13C, 1, 32'h123, 0, 32'h23, 0},
      '{12'h600, 1, 32'h55, 2, 0, 2}};
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [11:0] awaddr = 12'h000;
   logic [11:0] araddr = 12'h000;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic path_defect = 1'b0, c2_mismatch = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, j1_slot, tim_alarm, ais_out, rdi_out, irq;
   logic [1:0] bresp, rresp, rr;
   logic [31:0] rdata, d;
   char_t rx_j1, tx_j1;
   int bad_count = 0, cmp_count = 0, cyc = 0, p;

   // Short refresh period keeps the run brief
   path_trace_monitor #(.REFRESH_CYCLES(200)) i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
      .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready, .j1_slot, .rx_j1, .tx_j1, .path_defect, .c2_mismatch, .tim_alarm, .ais_out,
      .rdi_out, .irq);
   far_end_model i_far (.aclk, .aresetn, .j1_slot, .rx_j1, .tx_j1);

   initial begin
      forever #50 aclk = ~aclk;
   end

   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Hang guard, far above the expected run length
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         complete_run();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Write: both channels offered together, each dropped once taken
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
         if (bvalid) begin
            rr = bresp;
            bready <= 1'b0;
            break;
         end
      end
   endtask

   // Read: answer captured at the edge where rvalid is seen
   task automatic rd(input logic [11:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arvalid && arready)
            arvalid <= 1'b0;
         if (rvalid) begin
            d = rdata;
            rr = rresp;
            rready <= 1'b0;
            break;
         end
      end
   endtask

   // Short strings carry a marker in the first byte, long ones end in CR LF
   function automatic char_t sc(input int s, input int i, input int n);
      if (n == 16)
         return (i == 0) ? (8'hC0 | 8'(s)) : 8'(8'h30 + s + i);
      if (i >= 62)
         return (i == 62) ? `CHAR_CR : `CHAR_LF;
      return 8'(8'h41 + (s + i) % 26);
   endfunction

   task automatic set_far(input int s, input int n);
      for (int i = 0; i < 64; i++)
         i_far.str[i] = sc(s, i, n);
      i_far.len = n;
      i_far.idx = 0;
   endtask

   task automatic prog(input logic [11:0] base, input int s);
      for (int i = 0; i < 16; i++)
         wr(base + 12'(4 * i), 32'(sc(s, i, 16)));
   endtask

   // Let n whole strings pass at the far end's pace
   task automatic wstr(input int n);
      repeat (n * i_far.len * i_far.gap + 8) @(posedge aclk);
   endtask

   initial begin
      set_far(0, 16);
      for (int i = 0; i < 64; i++)
         i_far.str[i] = 8'h00;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      // Clear sweep runs 64 cycles after release
      repeat (70) @(posedge aclk);
      i_far.gap = 2;
      i_far.cap.delete();
      repeat (80) @(posedge aclk);
      foreach (i_far.cap[k])
         chk(i_far.cap[k], 0);
      // Register table after reset
      foreach (rows[k]) begin
         if (rows[k].w) begin
            wr(rows[k].a, rows[k].d);
            chk(rr, rows[k].wr);
         end
         rd(rows[k].a);
         chk(d, rows[k].e);
         chk(rr, rows[k].rr);
      end
      // Transmit string repeats one character per slot
      prog(12'h100, 1);
      i_far.cap.delete();
      repeat (140) @(posedge aclk);
      p = 0;
      while (p < 16 && i_far.cap[p] !== sc(1, 0, 16))
         p++;
      for (int i = 0; i < 32; i++)
         chk(i_far.cap[p + i], sc(1, i % 16, 16));
      // Manual mode: match, then mismatch with interrupt
      i_far.gap = 4;
      wr(`REG_INT_MASK, 32'h1);
      prog(12'h200, 2);
      set_far(2, 16);
      wr(`REG_CTRL, 32'(`MODE_MANUAL));
      wstr(4);
      chk(tim_alarm, 0);
      set_far(3, 16);
      wstr(3);
      chk(tim_alarm, 1);
      chk({ais_out, rdi_out, irq}, 3'b111);
      rd(`REG_INT_STAT);
      chk(d & 32'h1, 1);
      repeat (3) @(posedge aclk);
      chk(irq, 0);
      // Suppression options
      wr(`REG_CTRL, 32'(`MODE_MANUAL) | 32'h4);
      repeat (3) @(posedge aclk);
      chk({tim_alarm, ais_out, rdi_out}, 3'b100);
      c2_mismatch <= 1'b1;
      repeat (3) @(posedge aclk);
      chk({ais_out, rdi_out}, 2'b10);
      wr(`REG_CTRL, 32'(`MODE_MANUAL) | 32'hC);
      repeat (3) @(posedge aclk);
      chk(ais_out, 0);
      c2_mismatch <= 1'b0;
      path_defect <= 1'b1;
      repeat (3) @(posedge aclk);
      chk({ais_out, rdi_out}, 2'b11);
      path_defect <= 1'b0;
      set_far(2, 16);
      wstr(3);
      chk(tim_alarm, 0);
      // Auto mode learns a long string, then flags a new one
      set_far(5, 64);
      wr(`REG_CTRL, 32'(`MODE_AUTO));
      wstr(3);
      chk(tim_alarm, 0);
      rd(12'h300);
      chk(d, 32'(sc(5, 0, 64)));
      rd(`REG_STATUS);
      chk(d & 32'hA, 32'hA);
      set_far(6, 64);
      wstr(3);
      chk(tim_alarm, 1);
      rd(12'h400);
      chk(d, 32'(sc(6, 0, 64)));
      rd(12'h4F8);
      chk(d, 32'(`CHAR_CR));
      rd(12'h500);
      chk(d, 32'(sc(5, 0, 64)));
      // Receive only: checking goes on, nothing sent; a slot on the write edge may still carry a character
      wr(`REG_CTRL, 32'(`MODE_AUTO) | 32'h10);
      repeat (4) @(posedge aclk);
      i_far.cap.delete();
      repeat (160) @(posedge aclk);
      foreach (i_far.cap[k])
         chk(i_far.cap[k], 0);
      chk(tim_alarm, 1);
      // Restore defaults
      wr(`REG_CTRL, 32'h40);
      repeat (70) @(posedge aclk);
      rd(`REG_CTRL);
      chk(d, 0);
      rd(12'h100);
      chk(d, 0);
      rd(12'h200);
      chk(d, 0);
      chk(tim_alarm, 0);
      complete_run();
   end
endmodule
